/* File: mmpt_cfg.svh */
// Timing constants for the measurement and protection sequencer
`ifndef MMPT_CFG_SVH
`define MMPT_CFG_SVH
`define MMPT_CLK_KHZ         100000
`define MMPT_CS_SETTLE_NS    62000
`define MMPT_CS_REF3_NS      4096000
`define MMPT_CS_REF2_NS      1024000
`define MMPT_CS_REF1_NS      512000
`define MMPT_CS_REF0_NS      256000
`define MMPT_CS_CONV3_NS     12350000
`define MMPT_CS_CONV2_NS     3134000
`define MMPT_CS_CONV1_NS     1598000
`define MMPT_CS_CONV0_NS     830000
`define MMPT_ADC_CONV_NS     8000
`define MMPT_ADC_CYCLE_NS    192000
`define MMPT_CELL_SCAN_NS    8000000
`define MMPT_TEMP_SCAN_NS    4000000
`define MMPT_CELL_BIST_NS    23000000
`define MMPT_TEMP_BIST_NS    20000000
`define MMPT_PWR_BIST_NS     11500000
`define MMPT_CLK_NS          10
`endif

/* File: mmpt_pkg.sv */
// Types for the measurement and protection sequencer
package mmpt_pkg;
  typedef enum logic [1:0] {
    MMPT_CS_IDLE   = 2'b00,
    MMPT_CS_SETTLE = 2'b01,
    MMPT_CS_RUN    = 2'b11
  } mmpt_cs_state_t;
endpackage

/* File: mmpt_period_tick.sv */
// Free-running period counter producing one-cycle ticks
`timescale 1ns/1ns
`default_nettype none
module mmpt_period_tick #(
  parameter int W = 32
) (
  // Clocking
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic         clk_en,
  // Control
  input  wire logic         run,
  input  wire logic [W-1:0] period,
  // Result
  output logic              tick
);
  logic [W-1:0] count;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
      tick  <= 1'b0;
    end else if (clk_en) begin
      if (!run) begin
        count <= '0;
        tick  <= 1'b0;
      end else if (count >= period - W'(1)) begin
        count <= '0;
        tick  <= 1'b1;
      end else begin
        count <= count + W'(1);
        tick  <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* File: mmpt_sequencer.sv */
// Measurement and protection timing sequencer
`include "mmpt_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module mmpt_sequencer
  import mmpt_pkg::*;
#(
  parameter int W                 = 32,
  parameter int CS_SETTLE_CYC     = `MMPT_CS_SETTLE_NS / `MMPT_CLK_NS,
  parameter int CS_REF3_CYC       = `MMPT_CS_REF3_NS / `MMPT_CLK_NS,
  parameter int CS_REF2_CYC       = `MMPT_CS_REF2_NS / `MMPT_CLK_NS,
  parameter int CS_REF1_CYC       = `MMPT_CS_REF1_NS / `MMPT_CLK_NS,
  parameter int CS_REF0_CYC       = `MMPT_CS_REF0_NS / `MMPT_CLK_NS,
  parameter int CS_CONV3_CYC      = `MMPT_CS_CONV3_NS / `MMPT_CLK_NS,
  parameter int CS_CONV2_CYC      = `MMPT_CS_CONV2_NS / `MMPT_CLK_NS,
  parameter int CS_CONV1_CYC      = `MMPT_CS_CONV1_NS / `MMPT_CLK_NS,
  parameter int CS_CONV0_CYC      = `MMPT_CS_CONV0_NS / `MMPT_CLK_NS,
  parameter int ADC_CONV_CYC      = `MMPT_ADC_CONV_NS / `MMPT_CLK_NS,
  parameter int ADC_CYCLE_CYC     = `MMPT_ADC_CYCLE_NS / `MMPT_CLK_NS,
  parameter int CELL_SCAN_CYC     = `MMPT_CELL_SCAN_NS / `MMPT_CLK_NS,
  parameter int TEMP_SCAN_CYC     = `MMPT_TEMP_SCAN_NS / `MMPT_CLK_NS,
  parameter int CELL_BIST_CYC     = `MMPT_CELL_BIST_NS / `MMPT_CLK_NS,
  parameter int TEMP_BIST_CYC     = `MMPT_TEMP_BIST_NS / `MMPT_CLK_NS,
  parameter int PWR_BIST_CYC      = `MMPT_PWR_BIST_NS / `MMPT_CLK_NS
) (
  // Clocking
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  // Current-sense control
  input  wire logic       cs_enable,
  input  wire logic       cs_continuous,
  input  wire logic [1:0] current_sense_decimation_select,
  // Main converter, comparator and self-test control
  input  wire logic       main_adc_enable,
  input  wire logic       cell_limit_enable,
  input  wire logic       temp_limit_enable,
  input  wire logic       cell_bist_go,
  input  wire logic       temp_bist_go,
  input  wire logic       pwr_bist_go,
  // Current-sense status
  output logic            cs_valid,
  output logic            cs_result_tick,
  output logic            cs_busy,
  // Main converter
  output logic            main_conv_tick,
  output logic            main_cycle_tick,
  // Comparator scans
  output logic            cell_high_limit_check,
  output logic            cell_low_limit_check,
  output logic            temp_high_limit_check,
  output logic            temp_low_limit_check,
  // Self tests
  output logic            cell_bist_busy,
  output logic            cell_bist_done,
  output logic            temp_bist_busy,
  output logic            temp_bist_done,
  output logic            pwr_bist_busy,
  output logic            pwr_bist_done
);
  mmpt_cs_state_t cs_state;
  logic [W-1:0]   cs_count;
  logic [W-1:0]   cs_ref_period;
  logic [W-1:0]   cs_conv_period;
  logic [W-1:0]   cs_target;
  logic [4:0]     main_slot;
  logic           cell_tick;
  logic           temp_tick;
  logic [W-1:0]   cell_bist_count;
  logic [W-1:0]   temp_bist_count;
  logic [W-1:0]   pwr_bist_count;

  // Period lookup from the decimation select; all nominal, which keeps
  // the count error at zero and well inside the accuracy band
  always_comb begin
    case (current_sense_decimation_select)
      2'h3: begin
        cs_ref_period  = W'(CS_REF3_CYC);
        cs_conv_period = W'(CS_CONV3_CYC);
      end
      2'h2: begin
        cs_ref_period  = W'(CS_REF2_CYC);
        cs_conv_period = W'(CS_CONV2_CYC);
      end
      2'h1: begin
        cs_ref_period  = W'(CS_REF1_CYC);
        cs_conv_period = W'(CS_CONV1_CYC);
      end
      default: begin
        cs_ref_period  = W'(CS_REF0_CYC);
        cs_conv_period = W'(CS_CONV0_CYC);
      end
    endcase
    cs_target = cs_continuous ? cs_ref_period : cs_conv_period;
  end

  // Current-sense sequencing: settle, then refresh or one conversion
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_state       <= MMPT_CS_IDLE;
      cs_count       <= '0;
      cs_valid       <= 1'b0;
      cs_result_tick <= 1'b0;
    end else if (clk_en) begin
      cs_result_tick <= 1'b0;
      case (cs_state)
        MMPT_CS_IDLE: begin
          cs_count <= '0;
          if (cs_enable) begin
            cs_state <= MMPT_CS_SETTLE;
            cs_valid <= 1'b0;
          end
        end
        MMPT_CS_SETTLE: begin
          if (!cs_enable) begin
            cs_state <= MMPT_CS_IDLE;
          end else if (cs_count >= W'(CS_SETTLE_CYC) - W'(1)) begin
            cs_state <= MMPT_CS_RUN;
            cs_count <= '0;
          end else begin
            cs_count <= cs_count + W'(1);
          end
        end
        MMPT_CS_RUN: begin
          if (!cs_enable) begin
            cs_state <= MMPT_CS_IDLE;
            cs_valid <= 1'b0;
          end else if (cs_count >= cs_target - W'(1)) begin
            cs_count       <= '0;
            cs_valid       <= 1'b1;
            cs_result_tick <= 1'b1;
            // A single conversion returns to idle; a held enable starts a new settle on the next edge
            if (!cs_continuous) begin
              cs_state <= MMPT_CS_IDLE;
            end
          end else begin
            cs_count <= cs_count + W'(1);
          end
        end
        default: cs_state <= MMPT_CS_IDLE;
      endcase
    end
  end

  assign cs_busy = (cs_state != MMPT_CS_IDLE);

  // Main converter: 24 slots of one conversion each make one pass
  mmpt_period_tick #(.W(W)) u_main_conv (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .run      (main_adc_enable),
    .period   (W'(ADC_CONV_CYC)),
    .tick     (main_conv_tick)
  );

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      main_slot       <= '0;
      main_cycle_tick <= 1'b0;
    end else if (clk_en) begin
      main_cycle_tick <= 1'b0;
      if (!main_adc_enable) begin
        main_slot <= '0;
      end else if (main_conv_tick) begin
        if (main_slot >= 5'(ADC_CYCLE_CYC / ADC_CONV_CYC) - 5'd1) begin
          main_slot       <= '0;
          main_cycle_tick <= 1'b1;
        end else begin
          main_slot <= main_slot + 5'd1;
        end
      end
    end
  end

  // Cell scan pulses both high and low checks together
  mmpt_period_tick #(.W(W)) u_cell_scan (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .run      (cell_limit_enable),
    .period   (W'(CELL_SCAN_CYC)),
    .tick     (cell_tick)
  );

  // Temperature scan; the host holds off until the bias is stable
  mmpt_period_tick #(.W(W)) u_temp_scan (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .run      (temp_limit_enable),
    .period   (W'(TEMP_SCAN_CYC)),
    .tick     (temp_tick)
  );

  assign cell_high_limit_check = cell_tick;
  assign cell_low_limit_check  = cell_tick;
  assign temp_high_limit_check = temp_tick;
  assign temp_low_limit_check  = temp_tick;

  // Self-test timers; a go while busy is ignored
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cell_bist_busy  <= 1'b0;
      cell_bist_done  <= 1'b0;
      cell_bist_count <= '0;
    end else if (clk_en) begin
      cell_bist_done <= 1'b0;
      if (!cell_bist_busy) begin
        cell_bist_busy  <= cell_bist_go;
        cell_bist_count <= '0;
      end else if (cell_bist_count >= W'(CELL_BIST_CYC) - W'(1)) begin
        cell_bist_busy <= 1'b0;
        cell_bist_done <= 1'b1;
      end else begin
        cell_bist_count <= cell_bist_count + W'(1);
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      temp_bist_busy  <= 1'b0;
      temp_bist_done  <= 1'b0;
      temp_bist_count <= '0;
    end else if (clk_en) begin
      temp_bist_done <= 1'b0;
      if (!temp_bist_busy) begin
        temp_bist_busy  <= temp_bist_go;
        temp_bist_count <= '0;
      end else if (temp_bist_count >= W'(TEMP_BIST_CYC) - W'(1)) begin
        temp_bist_busy <= 1'b0;
        temp_bist_done <= 1'b1;
      end else begin
        temp_bist_count <= temp_bist_count + W'(1);
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_bist_busy  <= 1'b0;
      pwr_bist_done  <= 1'b0;
      pwr_bist_count <= '0;
    end else if (clk_en) begin
      pwr_bist_done <= 1'b0;
      if (!pwr_bist_busy) begin
        pwr_bist_busy  <= pwr_bist_go;
        pwr_bist_count <= '0;
      end else if (pwr_bist_count >= W'(PWR_BIST_CYC) - W'(1)) begin
        pwr_bist_busy <= 1'b0;
        pwr_bist_done <= 1'b1;
      end else begin
        pwr_bist_count <= pwr_bist_count + W'(1);
      end
    end
  end
endmodule
`default_nettype wire

/* File: mmpt_sequencer_props.sv */
// Checker for the measurement and protection sequencer
`timescale 1ns/1ns
`default_nettype none
module mmpt_seq_props #(
  parameter int CS_SETTLE_CYC = 10,
  parameter int CS_REF3_CYC   = 40,
  parameter int ADC_CONV_CYC  = 4,
  parameter int ADC_CYCLE_CYC = 96,
  parameter int CELL_SCAN_CYC = 16,
  parameter int TEMP_SCAN_CYC = 8,
  parameter int CELL_BIST_CYC = 23,
  parameter int TEMP_BIST_CYC = 20,
  parameter int PWR_BIST_CYC  = 11
) (
  // Clocking and control
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic       clk_en,
  input wire logic       cs_enable,
  input wire logic       cs_continuous,
  input wire logic [1:0] current_sense_decimation_select,
  input wire logic       cell_limit_enable,
  input wire logic       temp_limit_enable,
  input wire logic       main_adc_enable,
  input wire logic       pwr_bist_go,
  // Status
  input wire logic       cs_busy,
  input wire logic       cs_result_tick,
  input wire logic       main_conv_tick,
  input wire logic       main_cycle_tick,
  input wire logic       cell_high_limit_check,
  input wire logic       cell_low_limit_check,
  input wire logic       temp_high_limit_check,
  input wire logic       temp_low_limit_check,
  input wire logic       cell_bist_busy,
  input wire logic       cell_bist_done,
  input wire logic       temp_bist_busy,
  input wire logic       temp_bist_done,
  input wire logic       pwr_bist_busy,
  input wire logic       pwr_bist_done
);
  // One cycle of slack below and two above cover the state entry cycle
  localparam int FIRST_LO = CS_SETTLE_CYC + CS_REF3_CYC - 1;
  localparam int FIRST_HI = CS_SETTLE_CYC + CS_REF3_CYC + 2;
  // Wide enough for the full-length self tests at the nominal counts
  logic [31:0] pwr_cnt;
  logic [31:0] cell_cnt;
  logic [31:0] temp_cnt;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Busy cycles counted so each done pulse can be tied to the test length
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_cnt  <= 32'h0;
      cell_cnt <= 32'h0;
      temp_cnt <= 32'h0;
    end else if (clk_en) begin
      pwr_cnt  <= pwr_bist_busy ? pwr_cnt + 32'h1 : 32'h0;
      cell_cnt <= cell_bist_busy ? cell_cnt + 32'h1 : 32'h0;
      temp_cnt <= temp_bist_busy ? temp_cnt + 32'h1 : 32'h0;
    end
  end
  go_starts_busy_a: assert property (pwr_bist_go && !pwr_bist_busy && clk_en |=> pwr_bist_busy)
    else $error("supply test did not start");
  pwr_length_a: assert property (pwr_bist_done |-> int'(pwr_cnt) == PWR_BIST_CYC)
    else $error("supply test length wrong");
  cell_length_a: assert property (cell_bist_done |-> int'(cell_cnt) == CELL_BIST_CYC)
    else $error("cell test length wrong");
  temp_length_a: assert property (temp_bist_done |-> int'(temp_cnt) == TEMP_BIST_CYC)
    else $error("temp test length wrong");
  busy_ends_done_a: assert property ($fell(cell_bist_busy) |-> cell_bist_done)
    else $error("cell test ended without done");
  cell_scan_a: assert property (cell_high_limit_check && cell_limit_enable |->
    ##CELL_SCAN_CYC (cell_high_limit_check && cell_low_limit_check || !cell_limit_enable))
    else $error("cell scan period wrong");
  temp_scan_a: assert property (temp_high_limit_check && temp_limit_enable |->
    ##TEMP_SCAN_CYC (temp_high_limit_check && temp_low_limit_check || !temp_limit_enable))
    else $error("temp scan period wrong");
  conv_slot_a: assert property (main_conv_tick && main_adc_enable |->
    ##ADC_CONV_CYC (main_conv_tick || !main_adc_enable))
    else $error("conversion slot wrong");
  main_cycle_a: assert property (main_cycle_tick && main_adc_enable |->
    ##ADC_CYCLE_CYC (main_cycle_tick || !main_adc_enable))
    else $error("round robin period wrong");
  cs_first_a: assert property ($rose(cs_busy) && cs_continuous
    && current_sense_decimation_select == 2'h3 |-> ##[FIRST_LO:FIRST_HI] cs_result_tick)
    else $error("first current result late");
  cs_refresh_a: assert property (cs_result_tick && cs_continuous
    && current_sense_decimation_select == 2'h3 |->
    ##CS_REF3_CYC (cs_result_tick || !cs_enable || !cs_continuous))
    else $error("refresh period wrong");
endmodule
bind mmpt_sequencer mmpt_seq_props #(.CS_SETTLE_CYC(CS_SETTLE_CYC), .CS_REF3_CYC(CS_REF3_CYC),
  .ADC_CONV_CYC(ADC_CONV_CYC), .ADC_CYCLE_CYC(ADC_CYCLE_CYC), .CELL_SCAN_CYC(CELL_SCAN_CYC),
  .TEMP_SCAN_CYC(TEMP_SCAN_CYC), .CELL_BIST_CYC(CELL_BIST_CYC),
  .TEMP_BIST_CYC(TEMP_BIST_CYC), .PWR_BIST_CYC(PWR_BIST_CYC)) mmpt_seq_props_inst (.*);
`default_nettype wire

/* File: testbench.sv */
// Self-checking bench for the measurement and protection sequencer
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin num_errors++; \
  $display("[ERR] %0t got %0h want %0h", $time, (a), (b)); end end
module testbench;
  localparam int S = 10;
  localparam int REF_C [4] = '{8, 12, 20, 40};
  localparam int CONV_C [4] = '{16, 22, 30, 48};
  localparam int BIST_C [3] = '{23, 20, 11};
  localparam int PER_C [4] = '{16, 8, 4, 96};
  logic core_clk, rst_n, clk_en, cs_enable, cs_continuous;
  logic main_adc_enable, cell_limit_enable, temp_limit_enable;
  logic cs_valid, cs_result_tick, cs_busy;
  logic [1:0] dec;
  logic [1:0] lows;
  logic [2:0] go, busy, done;
  logic [3:0] tick;
  int num_errors, checks_done, cycles;
  mmpt_sequencer #(.CS_SETTLE_CYC(S), .CS_REF0_CYC(REF_C[0]), .CS_REF1_CYC(REF_C[1]),
    .CS_REF2_CYC(REF_C[2]), .CS_REF3_CYC(REF_C[3]), .CS_CONV0_CYC(CONV_C[0]),
    .CS_CONV1_CYC(CONV_C[1]), .CS_CONV2_CYC(CONV_C[2]), .CS_CONV3_CYC(CONV_C[3]),
    .ADC_CONV_CYC(PER_C[2]), .ADC_CYCLE_CYC(PER_C[3]), .CELL_SCAN_CYC(PER_C[0]),
    .TEMP_SCAN_CYC(PER_C[1]), .CELL_BIST_CYC(BIST_C[0]), .TEMP_BIST_CYC(BIST_C[1]),
    .PWR_BIST_CYC(BIST_C[2]))
  mmpt_sequencer_inst (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
    .cs_enable(cs_enable), .cs_continuous(cs_continuous),
    .current_sense_decimation_select(dec), .main_adc_enable(main_adc_enable),
    .cell_limit_enable(cell_limit_enable), .temp_limit_enable(temp_limit_enable),
    .cell_bist_go(go[0]), .temp_bist_go(go[1]), .pwr_bist_go(go[2]),
    .cs_valid(cs_valid), .cs_result_tick(cs_result_tick), .cs_busy(cs_busy),
    .main_conv_tick(tick[2]), .main_cycle_tick(tick[3]),
    .cell_high_limit_check(tick[0]), .cell_low_limit_check(lows[0]),
    .temp_high_limit_check(tick[1]), .temp_low_limit_check(lows[1]),
    .cell_bist_busy(busy[0]), .cell_bist_done(done[0]), .temp_bist_busy(busy[1]),
    .temp_bist_done(done[1]), .pwr_bist_busy(busy[2]), .pwr_bist_done(done[2]));
  always #5 core_clk = ~core_clk;
  task automatic summarize();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // A second go while busy must not restart the count; the supply test
  // also holds the clock enable low for three edges, which must stretch it
  task automatic run_bist(input int i);
    int n;
    @(posedge core_clk);
    go[i] <= 1'b1;
    n = 0;
    while (done[i] !== 1'b1 && n < 200) begin
      @(posedge core_clk);
      go[i] <= (n == 4);
      clk_en <= !(i == 2 && n >= 6 && n < 9);
      n++;
      #1;
    end
    `CHK(n, BIST_C[i] + 1 + ((i == 2) ? 3 : 0))
  endtask
  task automatic wait_tick(input int i, output int n);
    n = 0;
    do begin @(posedge core_clk); #1; n++; end while (tick[i] !== 1'b1 && n < 500);
  endtask
  task automatic run_scans();
    int n;
    @(posedge core_clk);
    cell_limit_enable <= 1'b1;
    // Bias taken as settled; the first temperature tick is discarded
    temp_limit_enable <= 1'b1;
    main_adc_enable <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wait_tick(i, n);
      wait_tick(i, n);
      `CHK(n, PER_C[i])
    end
    repeat (40) begin @(posedge core_clk); #1; `CHK(lows, tick[1:0]) end
  endtask
  task automatic run_cs(input int d, input logic cont, input int t);
    int n;
    @(posedge core_clk);
    dec <= 2'(d);
    cs_continuous <= cont;
    cs_enable <= 1'b1;
    n = 0;
    while (cs_result_tick !== 1'b1 && n < 500) begin @(posedge core_clk); n++; #1; end
    `CHK(n >= S + t && n <= S + t + 4, 1'b1)
    n = 0;
    do begin @(posedge core_clk); #1; n++; end while (cs_result_tick !== 1'b1 && n < 500);
    if (cont) `CHK(n, t)
    else `CHK(n, S + t + 1)
    `CHK(cs_valid, 1'b1)
    // Drop on an edge; a held enable re-arms a single conversion first
    @(posedge core_clk);
    cs_enable <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    `CHK({cs_busy, cs_valid}, 2'h0)
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin num_errors++; summarize(); end
  end
  initial begin
    {core_clk, rst_n, cs_enable, cs_continuous, main_adc_enable} = 5'h0;
    {cell_limit_enable, temp_limit_enable, dec, go} = 7'h0;
    clk_en = 1'b1;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    #1;
    `CHK({busy, done, tick, lows, cs_busy, cs_valid}, 14'h0)
    for (int i = 0; i < 3; i++) run_bist(i);
    run_scans();
    for (int d = 0; d < 4; d++) run_cs(d, 1'b1, REF_C[d]);
    for (int d = 0; d < 4; d++) run_cs(d, 1'b0, CONV_C[d]);
    summarize();
  end
endmodule
`default_nettype wire
